// File: sttp_pkg.sv
// Constants and types for the serial test transmit port.
package sttp_pkg;

  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int BYTE_W = 8;
  localparam int FRAME_BITS = 12;
  localparam int NUM_DAT = 3;
  localparam int FIFO_DEPTH = 8;

  localparam logic [31:0] KEY_FIRST_ADDR = 32'hffff0880;
  localparam logic [31:0] CTRL_ADDR = 32'hffff0884;
  localparam logic [31:0] KEY_SECOND_ADDR = 32'hffff0888;
  localparam logic [31:0] DAT_ONE_TWO_ADDR = 32'hffff088c;
  localparam logic [31:0] DAT_THREE_FOUR_ADDR = 32'hffff0890;
  localparam logic [31:0] DAT_FIVE_SIX_ADDR = 32'hffff0894;

  localparam logic [15:0] KEY_FIRST_VAL = 16'h0007;
  localparam logic [15:0] KEY_SECOND_VAL = 16'h00b9;
  localparam logic [15:0] DAT_RESET = 16'h0000;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_CNT_LO = 2;
  localparam int CTRL_CNT_HI = 4;
  localparam logic [2:0] CNT_MAX = 3'h5;
  localparam logic [3:0] STATE_LOADING = 4'hd;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'hc;
  localparam logic [3:0] BIT_STOP_FIRST = 4'hb;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ARMED = 2'b01,
    KEY_HELD = 2'b10
  } sttp_key_t;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_PUSH = 2'b01,
    LD_DRAIN = 2'b10
  } sttp_ld_t;

  typedef enum logic {
    SER_IDLE = 1'b0,
    SER_SHIFT = 1'b1
  } sttp_ser_t;

endpackage : sttp_pkg

// File: sttp_fifo.sv
// Byte FIFO between the loader and the serializer.
`timescale 1ns/1ps
module sttp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (clr) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        mem_d[wr_q] = in_data;
        wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_q <= '{default: '0};
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : sttp_fifo

// File: sttp_top.sv
// Serial test transmit port: APB registers, key lock, loader and serializer.
// Functional notes
// - Sends one to six bytes per run
// - Frame: start, eight data, parity, two stops
// - One bit per baud timer overflow
// - Control write without first key ignored
// - Second key must follow control write
// - Data registers give bytes low lane first
// - Control bits 4:2 hold byte count minus one
// - State bits nonzero while sending
// - Control bit 1 resets port
// - Control bit 0 enables port
// - Sending starts without further software action
// - Wait until needed data registers written
// - Control reads back written value when done
`timescale 1ns/1ps
module sttp_top #(
  parameter logic PARITY_ODD = 1'h0,
  parameter int FIFO_DEPTH = sttp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Baud timer overflow pulse
  input wire logic baud_tick,
  // Test pin
  output logic test_pin
);
  localparam int BW = sttp_pkg::BYTE_W;
  localparam int RW = sttp_pkg::REG_W;

  function automatic logic [RW-1:0] merge16(input logic [RW-1:0] old_v,
                                            input logic [RW-1:0] new_v,
                                            input logic [1:0] strb);
    logic [RW-1:0] r;
    r = old_v;
    if (strb[0]) r[BW-1:0] = new_v[BW-1:0];
    if (strb[1]) r[RW-1:BW] = new_v[RW-1:BW];
    return r;
  endfunction : merge16

  function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
    return a == reg_addr;
  endfunction : hit

  // Register state
  sttp_pkg::sttp_key_t key_q, key_d;
  logic [RW-1:0] held_q, held_d;
  logic ctrl_en_q, ctrl_en_d;
  logic [2:0] ctrl_cnt_q, ctrl_cnt_d;
  logic [RW-1:0] dat_q [sttp_pkg::NUM_DAT];
  logic [RW-1:0] dat_d [sttp_pkg::NUM_DAT];
  logic [sttp_pkg::NUM_DAT-1:0] wr_q, wr_d;
  logic [31:0] prdata_q, prdata_d;
  // Loader and serializer state
  sttp_pkg::sttp_ld_t ld_q, ld_d;
  logic [2:0] idx_q, idx_d;
  sttp_pkg::sttp_ser_t ser_q, ser_d;
  logic [sttp_pkg::FRAME_BITS-1:0] frame_q, frame_d;
  logic [3:0] bitn_q, bitn_d;

  logic xfer, setup, commit, soft_rst, done, loaded_ok, flush;
  logic [2:0] last_idx;
  logic [sttp_pkg::NUM_DAT-1:0] need;
  logic [3:0] state_bits;
  logic [RW-1:0] ctrl_rd, wdat;
  logic push_valid, push_ready, pop_valid, pop_ready, ser_load;
  logic [BW-1:0] push_data, pop_data;

  assign setup = psel && !penable;
  assign xfer = psel && penable;
  assign pready = xfer;
  assign wdat = pwdata[RW-1:0];
  assign pslverr = xfer && !(hit(paddr, sttp_pkg::KEY_FIRST_ADDR)
                   || hit(paddr, sttp_pkg::CTRL_ADDR)
                   || hit(paddr, sttp_pkg::KEY_SECOND_ADDR)
                   || hit(paddr, sttp_pkg::DAT_ONE_TWO_ADDR)
                   || hit(paddr, sttp_pkg::DAT_THREE_FOUR_ADDR)
                   || hit(paddr, sttp_pkg::DAT_FIVE_SIX_ADDR));
  assign prdata = prdata_q;

  assign commit = (key_q == sttp_pkg::KEY_HELD) && xfer && pwrite
                  && hit(paddr, sttp_pkg::KEY_SECOND_ADDR)
                  && (wdat == sttp_pkg::KEY_SECOND_VAL);
  assign soft_rst = commit && held_q[sttp_pkg::CTRL_RST_BIT];
  assign flush = soft_rst || !ctrl_en_q;

  assign last_idx = (ctrl_cnt_q > sttp_pkg::CNT_MAX) ? sttp_pkg::CNT_MAX : ctrl_cnt_q;

  always_comb begin
    for (int r = 0; r < sttp_pkg::NUM_DAT; r++) begin
      need[r] = (3'(2 * r) <= last_idx);
    end
  end
  assign loaded_ok = &(wr_q | ~need);

  // nonzero while a run is active
  assign state_bits = (ser_q == sttp_pkg::SER_SHIFT) ? bitn_q
                      : (ld_q != sttp_pkg::LD_IDLE) ? sttp_pkg::STATE_LOADING : 4'h0;
  // reads back written value once idle
  assign ctrl_rd = {7'h00, state_bits, ctrl_cnt_q, 1'h0, ctrl_en_q};

  always_comb begin
    key_d = key_q;
    held_d = held_q;
    ctrl_en_d = ctrl_en_q;
    ctrl_cnt_d = ctrl_cnt_q;
    dat_d = dat_q;
    wr_d = wr_q;
    prdata_d = prdata_q;
    if (setup && !pwrite) begin
      prdata_d = '0;
      if (hit(paddr, sttp_pkg::CTRL_ADDR)) prdata_d[RW-1:0] = ctrl_rd;
      for (int r = 0; r < sttp_pkg::NUM_DAT; r++) begin
        if (hit(paddr, sttp_pkg::DAT_ONE_TWO_ADDR + 32'(4 * r))) prdata_d[RW-1:0] = dat_q[r];
      end
    end
    if (done) wr_d = '0;
    if (xfer) begin
      // any other access drops the key state
      key_d = sttp_pkg::KEY_IDLE;
      if (pwrite && hit(paddr, sttp_pkg::KEY_FIRST_ADDR) && wdat == sttp_pkg::KEY_FIRST_VAL) begin
        key_d = sttp_pkg::KEY_ARMED;
      end
      // control write only after first key
      if (key_q == sttp_pkg::KEY_ARMED && pwrite && hit(paddr, sttp_pkg::CTRL_ADDR)) begin
        key_d = sttp_pkg::KEY_HELD;
        held_d = wdat;
      end
      if (commit) begin
        ctrl_en_d = held_q[sttp_pkg::CTRL_EN_BIT];
        ctrl_cnt_d = held_q[sttp_pkg::CTRL_CNT_HI:sttp_pkg::CTRL_CNT_LO];
        wr_d = '0;
      end
      for (int r = 0; r < sttp_pkg::NUM_DAT; r++) begin
        if (pwrite && hit(paddr, sttp_pkg::DAT_ONE_TWO_ADDR + 32'(4 * r))) begin
          dat_d[r] = merge16(dat_q[r], wdat, pstrb[1:0]);
          wr_d[r] = 1'h1;
        end
      end
    end
    if (soft_rst) begin
      ctrl_en_d = 1'h0;
      ctrl_cnt_d = 3'h0;
      dat_d = '{default: sttp_pkg::DAT_RESET};
      wr_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= sttp_pkg::KEY_IDLE;
      held_q <= '0;
      ctrl_en_q <= 1'h0;
      ctrl_cnt_q <= 3'h0;
      dat_q <= '{default: sttp_pkg::DAT_RESET};
      wr_q <= '0;
      prdata_q <= '0;
    end else begin
      key_q <= key_d;
      held_q <= held_d;
      ctrl_en_q <= ctrl_en_d;
      ctrl_cnt_q <= ctrl_cnt_d;
      dat_q <= dat_d;
      wr_q <= wr_d;
      prdata_q <= prdata_d;
    end
  end

  // byte one from low lane of first register
  assign push_data = idx_q[0] ? dat_q[idx_q[2:1]][RW-1:BW] : dat_q[idx_q[2:1]][BW-1:0];

  always_comb begin
    ld_d = ld_q;
    idx_d = idx_q;
    push_valid = 1'h0;
    done = 1'h0;
    unique case (ld_q)
      sttp_pkg::LD_IDLE: begin
        if (ctrl_en_q && loaded_ok) begin
          ld_d = sttp_pkg::LD_PUSH;
          idx_d = 3'h0;
        end
      end
      sttp_pkg::LD_PUSH: begin
        push_valid = 1'h1;
        if (push_ready) begin
          if (idx_q == last_idx) ld_d = sttp_pkg::LD_DRAIN;
          else idx_d = idx_q + 3'h1;
        end
      end
      sttp_pkg::LD_DRAIN: begin
        if (!pop_valid && ser_q == sttp_pkg::SER_IDLE) begin
          done = 1'h1;
          ld_d = sttp_pkg::LD_IDLE;
        end
      end
      default: ld_d = sttp_pkg::LD_IDLE;
    endcase
    if (flush) begin
      ld_d = sttp_pkg::LD_IDLE;
      push_valid = 1'h0;
      done = 1'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_q <= sttp_pkg::LD_IDLE;
      idx_q <= 3'h0;
    end else begin
      ld_q <= ld_d;
      idx_q <= idx_d;
    end
  end

  sttp_fifo #(
    .WIDTH(BW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .clr(flush),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // frames start only on a timer overflow
  assign pop_ready = baud_tick && !flush
                     && (ser_q == sttp_pkg::SER_IDLE || bitn_q == sttp_pkg::BIT_LAST);
  assign ser_load = pop_ready && pop_valid;
  assign test_pin = frame_q[0];

  always_comb begin
    ser_d = ser_q;
    frame_d = frame_q;
    bitn_d = bitn_q;
    if (ser_load) begin
      // stops, parity, data, start; parity sense
      frame_d = {2'h3, (^pop_data) ^ PARITY_ODD, pop_data, 1'h0};
      bitn_d = sttp_pkg::BIT_FIRST;
      ser_d = sttp_pkg::SER_SHIFT;
    end else if (ser_q == sttp_pkg::SER_SHIFT && baud_tick) begin
      if (bitn_q == sttp_pkg::BIT_LAST) begin
        ser_d = sttp_pkg::SER_IDLE;
        frame_d = '1;
        bitn_d = 4'h0;
      end else begin
        // shift out LSB first, fill with idle level
        frame_d = {1'h1, frame_q[sttp_pkg::FRAME_BITS-1:1]};
        bitn_d = bitn_q + 4'h1;
      end
    end
    if (flush) begin
      ser_d = sttp_pkg::SER_IDLE;
      frame_d = '1;
      bitn_d = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_q <= sttp_pkg::SER_IDLE;
      frame_q <= '1;
      bitn_q <= 4'h0;
    end else begin
      ser_q <= ser_d;
      frame_q <= frame_d;
      bitn_q <= bitn_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_push_count: assert property ((ld_q == sttp_pkg::LD_PUSH) |-> (idx_q <= last_idx))
    else $error("loader index beyond byte count");

  a_start_bit: assert property (ser_load && !flush |=> !test_pin)
    else $error("start bit not low");

  a_stop_bits: assert property ((ser_q == sttp_pkg::SER_SHIFT
    && bitn_q >= sttp_pkg::BIT_STOP_FIRST) |-> test_pin)
    else $error("stop bit not high");

  // pin changes only on a tick or a flush
  a_bit_pace: assert property (!baud_tick && !flush |=> $stable(test_pin))
    else $error("pin moved without overflow");

  a_key_reject: assert property (xfer && pwrite && hit(paddr, sttp_pkg::CTRL_ADDR)
    && key_q != sttp_pkg::KEY_ARMED |=> key_q == sttp_pkg::KEY_IDLE
    && $stable(ctrl_en_q) && $stable(ctrl_cnt_q))
    else $error("control changed without first key");

  a_key_discard: assert property (key_q == sttp_pkg::KEY_HELD && xfer && !commit
    |=> $stable(ctrl_en_q) && $stable(ctrl_cnt_q))
    else $error("control changed without second key");

  a_state_busy: assert property ((ser_q == sttp_pkg::SER_SHIFT
    || ld_q != sttp_pkg::LD_IDLE) |-> state_bits != 4'h0)
    else $error("state bits zero during transmission");

  a_soft_reset: assert property (soft_rst |=> ctrl_rd == 16'h0000 [*2])
    else $error("control not zero after port reset");

  a_disable_idle: assert property (!ctrl_en_q |=> ser_q == sttp_pkg::SER_IDLE
    && ld_q == sttp_pkg::LD_IDLE)
    else $error("disabled port still active");

  a_hold_off: assert property (ld_q == sttp_pkg::LD_IDLE && !loaded_ok
    |=> ld_q == sttp_pkg::LD_IDLE)
    else $error("transmission began before data written");

  a_parity: assert property (ser_load && !flush |=> (^frame_q[9:1]) == PARITY_ODD)
    else $error("parity bit wrong");

  a_idle_high: assert property ((ser_q == sttp_pkg::SER_IDLE) |-> test_pin)
    else $error("line not high when idle");

endmodule : sttp_top

// File: sttp_rx_model.sv
// Behavioural diagnostic receiver listening on the test pin.
`timescale 1ns/1ps
module sttp_rx_model #(
  parameter logic PARITY_ODD = 1'h0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Line side
  input wire logic baud_tick,
  input wire logic line,
  // Received bytes
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_err
);
  int n;
  logic [10:0] sh;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n = 0;
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      if (baud_tick && n == 0) begin
        if (line === 1'b0) n = 1;
      end else if (baud_tick) begin
        sh[n-1] = line;
        n = n + 1;
        if (n == 12) begin
          n = 0;
          rx_valid <= 1'b1;
          rx_byte <= sh[7:0];
          rx_err <= ((^sh[8:0]) !== PARITY_ODD) || (sh[10:9] !== 2'b11);
        end
      end
    end
  end
endmodule : sttp_rx_model

// File: tb_serial_test_tx_port.sv
// Self-checking bench for the serial test transmit port.
`timescale 1ns/1ps
module tb_serial_test_tx_port;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic baud_tick = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic test_pin;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_err;
  logic [7:0] rxq[$];
  int failures = 0;
  int cmp_count = 0;

  always #2.5 pclk = ~pclk;

  sttp_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .baud_tick(baud_tick),
    .test_pin(test_pin));
  // test pin routed straight to the receiver
  sttp_rx_model rx (.pclk(pclk), .presetn(presetn), .baud_tick(baud_tick),
    .line(test_pin), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_err(rx_err));

  // Baud overflow every fourth cycle
  always @(posedge pclk) begin
    tick_cnt <= tick_cnt + 2'h1;
    baud_tick <= (tick_cnt == 2'h3);
  end

  always @(posedge pclk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    if (presetn && rx_err !== 1'b0) begin
      failures++;
      $display("wrong value at %0t ns: bad frame", $time);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic [31:0] a, input logic w, input logic [15:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave; only the watchdog ends a stalled access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string m);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b0, 16'h0000, r, e);
    chk(r, exp, m);
  endtask : rd_chk

  task automatic commit(input logic [15:0] c);
    wr(sttp_pkg::KEY_FIRST_ADDR, sttp_pkg::KEY_FIRST_VAL);
    wr(sttp_pkg::CTRL_ADDR, c);
    wr(sttp_pkg::KEY_SECOND_ADDR, sttp_pkg::KEY_SECOND_VAL);
  endtask : commit

  function automatic logic [7:0] bval(input int k, input logic [7:0] base);
    return 8'(base + 8'h2b * k);
  endfunction : bval

  task automatic load(input int n, input logic [7:0] base);
    for (int k = 0; k < (n + 1) / 2; k++) begin
      wr(sttp_pkg::DAT_ONE_TWO_ADDR + 32'(4 * k), {bval(2 * k + 1, base), bval(2 * k, base)});
    end
  endtask : load

  task automatic expect_run(input int n, input logic [7:0] base, input logic [15:0] c);
    logic [31:0] r;
    logic e;
    int k;
    k = 0;
    while (rxq.size() < n && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(rxq.size()), 32'(n), "byte count");
    for (k = 0; k < n && k < rxq.size(); k++) begin
      chk({24'h0, rxq[k]}, {24'h0, bval(k, base)}, "byte");
    end
    k = 0;
    do begin
      xfer(sttp_pkg::CTRL_ADDR, 1'b0, 16'h0000, r, e);
      k++;
    end while (r !== {16'h0, c} && k < 40);
    chk(r, {16'h0, c}, "control after run");
    chk({31'h0, test_pin}, 32'h1, "idle pin");
    rxq.delete();
  endtask : expect_run

  task automatic t_reset();
    rd_chk(sttp_pkg::CTRL_ADDR, 32'h0, "control reset");
    for (int k = 0; k < 3; k++) begin
      rd_chk(sttp_pkg::DAT_ONE_TWO_ADDR + 32'(4 * k), 32'h0, "data reset");
    end
    wr(sttp_pkg::DAT_THREE_FOUR_ADDR, 16'ha55a);
    rd_chk(sttp_pkg::DAT_THREE_FOUR_ADDR, 32'h0000a55a, "data rw");
    // Upper lane only: low byte must keep its old value
    pstrb <= 4'h2;
    wr(sttp_pkg::DAT_THREE_FOUR_ADDR, 16'h3cc3);
    pstrb <= 4'hf;
    rd_chk(sttp_pkg::DAT_THREE_FOUR_ADDR, 32'h00003c5a, "data lane");
  endtask : t_reset

  task automatic t_send(input int n);
    logic [15:0] c;
    logic [31:0] r;
    logic e;
    c = {11'h0, 3'(n - 1), 2'b01};
    commit(c);
    rxq.delete();
    load(n, 8'(8'h17 * n));
    xfer(sttp_pkg::CTRL_ADDR, 1'b0, 16'h0000, r, e);
    chk({31'h0, r[8:5] != 4'h0}, 32'h1, "state busy");
    expect_run(n, 8'(8'h17 * n), c);
  endtask : t_send

  task automatic t_keys();
    logic [31:0] r;
    logic e;
    commit(16'h0010);
    wr(sttp_pkg::KEY_FIRST_ADDR, 16'h0006);
    wr(sttp_pkg::CTRL_ADDR, 16'h0005);
    wr(sttp_pkg::KEY_SECOND_ADDR, sttp_pkg::KEY_SECOND_VAL);
    rd_chk(sttp_pkg::CTRL_ADDR, 32'h10, "wrong first key");
    wr(sttp_pkg::CTRL_ADDR, 16'h0005);
    wr(sttp_pkg::KEY_SECOND_ADDR, sttp_pkg::KEY_SECOND_VAL);
    rd_chk(sttp_pkg::CTRL_ADDR, 32'h10, "no first key");
    wr(sttp_pkg::KEY_FIRST_ADDR, sttp_pkg::KEY_FIRST_VAL);
    wr(sttp_pkg::CTRL_ADDR, 16'h0005);
    rd_chk(sttp_pkg::KEY_SECOND_ADDR, 32'h0, "key reads zero");
    wr(sttp_pkg::KEY_SECOND_ADDR, sttp_pkg::KEY_SECOND_VAL);
    rd_chk(sttp_pkg::CTRL_ADDR, 32'h10, "broken second key");
    wr(sttp_pkg::KEY_FIRST_ADDR, sttp_pkg::KEY_FIRST_VAL);
    wr(sttp_pkg::CTRL_ADDR, 16'h0005);
    wr(sttp_pkg::KEY_SECOND_ADDR, 16'h00b8);
    rd_chk(sttp_pkg::CTRL_ADDR, 32'h10, "wrong second key");
    commit(16'h0012);
    rd_chk(sttp_pkg::CTRL_ADDR, 32'h0, "port reset");
    xfer(32'hffff0898, 1'b0, 16'h0000, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
  endtask : t_keys

  task automatic t_hold();
    rxq.delete();
    commit(16'h000d);
    load(2, 8'h61);
    repeat (200) @(posedge pclk);
    chk(32'(rxq.size()), 32'h0, "held without data");
    commit(16'h000c);
    load(4, 8'h61);
    repeat (200) @(posedge pclk);
    chk(32'(rxq.size()), 32'h0, "sent while disabled");
    commit(16'h000d);
    load(4, 8'h61);
    expect_run(4, 8'h61, 16'h000d);
  endtask : t_hold

  task automatic conclude();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    for (int n = 1; n <= 6; n++) begin
      t_send(n);
    end
    t_keys();
    t_hold();
    conclude();
  end

  initial begin
    #100000;
    failures++;
    conclude();
  end
endmodule : tb_serial_test_tx_port
